// File: mcc_mem_if.sv
// Carrier between the chain and its filter state memory.
`timescale 1ns/1ns
`default_nettype none
interface mcc_mem_if #(parameter int AW = 2, parameter int DW = 26);
    logic [AW-1:0] addr;
    logic          we;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport ctrl (output addr, output we, output wdata, input rdata);
    modport mem  (input addr, input we, input wdata, output rdata);
endinterface : mcc_mem_if
`default_nettype wire

// File: mcc_pkg.sv
// Shared constants and types for the measurement conditioning chain.
package mcc_pkg;
    localparam logic [7:0]  MCC_CTRL_OFS      = 8'h00;
    localparam logic [7:0]  MCC_STAT_OFS      = 8'h04;
    localparam logic [7:0]  MCC_CH_BASE       = 8'h10;
    localparam logic [7:0]  MCC_CH_STRIDE     = 8'h10;
    localparam logic [3:0]  MCC_CH_CFG        = 4'h0;
    localparam logic [3:0]  MCC_CH_OFFS       = 4'h4;
    localparam logic [3:0]  MCC_CH_THR        = 4'h8;
    localparam logic [3:0]  MCC_CH_RES        = 4'hc;
    localparam int          MCC_CTRL_FAST_BIT = 0;
    localparam int          MCC_CTRL_USE_LSB  = 8;
    localparam int          MCC_CFG_FILT_LSB  = 0;
    localparam int          MCC_CFG_BIP_BIT   = 4;
    localparam int          MCC_CFG_USER_BIT  = 5;
    localparam int          MCC_THR_HI_LSB    = 16;
    localparam int          MCC_STAT_PRIM_LSB = 8;
    localparam logic [2:0]  MCC_FILT_MAX      = 3'h6;
    localparam logic signed [15:0] MCC_OFFS_LIM = 16'sd1500;
    localparam logic signed [18:0] MCC_STD_FULL = 19'sd10000;
    localparam logic signed [18:0] MCC_STD_ZERO = 19'sd0;
    localparam logic signed [15:0] MCC_SAT_HI   = 16'sh7fff;
    localparam logic signed [15:0] MCC_SAT_LO   = 16'sh8000;
    localparam logic [31:0] MCC_CTRL_RST      = 32'h0000_0f00;
    // Reciprocals of the standardized spans, scaled by two to the MCC_SCALE_SH.
    localparam logic signed [18:0] MCC_K_UNI  = 19'sd107374;
    localparam logic signed [18:0] MCC_K_BIP  = 19'sd53687;
    localparam int          MCC_SCALE_SH      = 30;
    localparam int          MCC_FRAC          = 8;
    localparam int          MCC_SW            = 26;
    localparam int          MCC_CLK_NS        = 20;
    localparam int          MCC_MS_NS         = 1000000;
    localparam int          MCC_MS_CYC        = MCC_MS_NS / MCC_CLK_NS;
    localparam logic [3:0]  MCC_T_NORMAL_MS   = 4'd5;
    localparam logic [3:0]  MCC_T_FAST_MS     = 4'd1;
    typedef enum logic [2:0] {S_IDLE, S_READ, S_FILT, S_SCALE, S_PUSH} mcc_state_t;
endpackage : mcc_pkg

// File: mcc_sink_model.sv
// Controller-side consumer of results, prompt or stalling at random.
`timescale 1ns/1ns
`default_nettype none
module mcc_sink_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    output logic     res_ready
);
    // While slow, ready is withdrawn on about half the cycles to fill the buffer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_ready <= 1'b0;
        end else begin
            res_ready <= !slow || ($urandom_range(1, 0) == 1);
        end
    end
endmodule : mcc_sink_model
`default_nettype wire

// File: mcc_state_mem.sv
// Per-channel filter state memory with registered read data.
`timescale 1ns/1ns
`default_nettype none
module mcc_state_mem #(
    parameter int DEPTH = 4,
    parameter int DW    = 26
) (
    input wire logic pclk,
    input wire logic presetn,
    mcc_mem_if.mem   port
);
    logic [DW-1:0] store [DEPTH];

    always_ff @(posedge pclk) begin
        if (port.we) begin
            store[port.addr] <= port.wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port.rdata <= '0;
        end else begin
            port.rdata <= store[port.addr];
        end
    end
endmodule : mcc_state_mem
`default_nettype wire

// File: mcc_top.sv
// Measurement conditioning chain: alignment, first-order filter and scaling per channel.
//
// Overview of operation
// - Unipolar standardized result runs 0 at range minimum to 10000 at maximum.
// - Bipolar standardized result runs -10000 at minimum to 10000 at maximum.
// - User format maps range ends to lower and upper thresholds, each 16-bit signed.
// - User format result varies linearly between the two thresholds.
// - Filtered value is alpha times previous plus one minus alpha times new sample.
// - Filter setting 0..6 selects alpha 0, 0.750 up to 0.992; 0 means none.
// - Filter setting may change any time and applies to following samples.
// - Filter setting written by console or program is treated alike.
// - Filtering runs in both normal and fast scan modes.
// - One filter update per channel per scan cycle; normal cycle is 5 ms.
// - Each channel keeps its own alignment offset, readable and writable at run time.
// - Each channel shows whether an alignment offset has been applied.
// - Alignment offset is limited to plus or minus 1500.
// - Alignment acts in normal running without changing channel modes.
// - Fast mode scans in-use channels only, cycle 1 ms plus 1 ms each.
`timescale 1ns/1ns
`default_nettype none
module mcc_top
    import mcc_pkg::*;
#(
    parameter int NCH    = 4,
    parameter int MS_CYC = MCC_MS_CYC,
    parameter int CHW    = $clog2(NCH)
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               raw_valid,
    input  wire logic [CHW-1:0]     raw_ch,
    input  wire logic signed [15:0] raw_data,
    output logic                    res_valid,
    input  wire logic               res_ready,
    output logic [CHW-1:0]          res_ch,
    output logic signed [15:0]      res_data
);
    if (NCH < 2 || NCH > 8 || MS_CYC < 2) begin : g_bad
        $error("mcc_top: NCH must be 2..8 and MS_CYC at least 2");
    end

    mcc_mem_if #(.AW(CHW), .DW(MCC_SW)) mem_bus ();
    mcc_state_mem #(.DEPTH(NCH), .DW(MCC_SW)) u_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .port    (mem_bus.mem)
    );

    function automatic logic ch_hit(input logic [7:0] a, input int n);
        return (a >= MCC_CH_BASE) && (a < 8'(int'(MCC_CH_BASE) + n * int'(MCC_CH_STRIDE)))
            && (a[1:0] == 2'b00);
    endfunction : ch_hit

    function automatic logic [CHW-1:0] ch_of(input logic [7:0] a);
        logic [7:0] rel;
        rel = a - MCC_CH_BASE;
        return CHW'(rel[7:4]);
    endfunction : ch_of

    // Register state.
    logic [31:0]              ctrl_r;
    logic [2:0]               filt_r     [NCH];
    logic                     bip_r      [NCH];
    logic                     user_r     [NCH];
    logic signed [15:0]       offs_r     [NCH];
    logic signed [15:0]       lo_r       [NCH];
    logic signed [15:0]       hi_r       [NCH];
    logic signed [15:0]       result_r   [NCH];
    logic signed [15:0]       raw_r      [NCH];
    logic [NCH-1:0]           aligned_r;
    logic [NCH-1:0]           primed_r;
    logic [NCH-1:0]           have_r;
    logic [NCH-1:0]           pend_r;

    wire logic           setup  = psel & ~penable;
    wire logic           commit = psel & penable & pready;
    wire logic           wr_en  = commit & pwrite;
    wire logic [CHW-1:0] wch    = ch_of(paddr);
    wire logic           wch_ok = ch_hit(paddr, NCH);
    wire logic           fast   = ctrl_r[MCC_CTRL_FAST_BIT];
    wire logic [NCH-1:0] in_use = ctrl_r[MCC_CTRL_USE_LSB +: NCH];

    // Processing pipeline state.
    mcc_state_t               st_r;
    logic [CHW-1:0]           cur_r;
    logic signed [MCC_SW-1:0] filt_val_r;
    logic signed [15:0]       scaled_r;
    logic signed [MCC_SW-1:0] f_nxt;
    logic signed [15:0]       s_nxt;
    logic                     buf_in_ready;
    wire logic                push = (st_r == S_PUSH) && buf_in_ready;

    // APB slave, zero wait states.
    logic [31:0] rd_nxt;
    logic        err_nxt;
    always_comb begin
        rd_nxt  = 32'h0000_0000;
        err_nxt = 1'b0;
        if (paddr == MCC_CTRL_OFS) begin
            rd_nxt = ctrl_r;
        end else if (paddr == MCC_STAT_OFS) begin
            rd_nxt[NCH-1:0]                   = aligned_r;
            rd_nxt[MCC_STAT_PRIM_LSB +: NCH]  = primed_r;
        end else if (wch_ok) begin
            case (paddr[3:0])
                MCC_CH_CFG: begin
                    rd_nxt[MCC_CFG_FILT_LSB +: 3] = filt_r[wch];
                    rd_nxt[MCC_CFG_BIP_BIT]       = bip_r[wch];
                    rd_nxt[MCC_CFG_USER_BIT]      = user_r[wch];
                end
                MCC_CH_OFFS: rd_nxt = 32'(offs_r[wch]);
                MCC_CH_THR:  rd_nxt = {hi_r[wch], lo_r[wch]};
                MCC_CH_RES:  rd_nxt = 32'(result_r[wch]);
                default:     err_nxt = 1'b1;
            endcase
        end else begin
            err_nxt = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & err_nxt;
            prdata  <= (setup & ~pwrite) ? rd_nxt : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= MCC_CTRL_RST;
        end else if (wr_en && paddr == MCC_CTRL_OFS) begin
            ctrl_r <= pwdata & (32'h1 | (32'((1 << NCH) - 1) << MCC_CTRL_USE_LSB));
        end
    end

    // Channel configuration; console and program writes arrive alike on this bus.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NCH; i++) begin
                filt_r[i] <= 3'h0;
                bip_r[i]  <= 1'b0;
                user_r[i] <= 1'b0;
                lo_r[i]   <= 16'sh0000;
                hi_r[i]   <= 16'sh0000;
            end
        end else if (wr_en && wch_ok) begin
            if (paddr[3:0] == MCC_CH_CFG) begin
                filt_r[wch] <= (pwdata[MCC_CFG_FILT_LSB +: 3] > MCC_FILT_MAX) ?
                               MCC_FILT_MAX : pwdata[MCC_CFG_FILT_LSB +: 3];
                bip_r[wch]  <= pwdata[MCC_CFG_BIP_BIT];
                user_r[wch] <= pwdata[MCC_CFG_USER_BIT];
            end else if (paddr[3:0] == MCC_CH_THR) begin
                lo_r[wch] <= pwdata[15:0];
                hi_r[wch] <= pwdata[MCC_THR_HI_LSB +: 16];
            end
        end
    end

    // Alignment offsets, clamped at the limit; writing zero removes the alignment.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NCH; i++) begin
                offs_r[i] <= 16'sh0000;
            end
            aligned_r <= '0;
        end else if (wr_en && wch_ok && paddr[3:0] == MCC_CH_OFFS) begin
            if ($signed(pwdata[15:0]) > MCC_OFFS_LIM) begin
                offs_r[wch] <= MCC_OFFS_LIM;
            end else if ($signed(pwdata[15:0]) < -MCC_OFFS_LIM) begin
                offs_r[wch] <= -MCC_OFFS_LIM;
            end else begin
                offs_r[wch] <= pwdata[15:0];
            end
            aligned_r[wch] <= (pwdata[15:0] != 16'h0000);
        end
    end

    // Latest raw sample per channel.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NCH; i++) begin
                raw_r[i] <= 16'sh0000;
            end
            have_r <= '0;
        end else if (raw_valid && int'(raw_ch) < NCH) begin
            raw_r[raw_ch]  <= raw_data;
            have_r[raw_ch] <= 1'b1;
        end
    end

    // Millisecond enable and scan cycle timer.
    logic [$clog2(MS_CYC)-1:0] ms_cnt_r;
    logic [3:0]                scan_ms_r;
    logic [3:0]                period;
    wire logic                 ms_tick = (ms_cnt_r == ($clog2(MS_CYC))'(MS_CYC - 1));
    always_comb begin
        period = MCC_T_NORMAL_MS;
        if (fast) begin
            period = MCC_T_FAST_MS + 4'($countones(in_use));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt_r <= '0;
        end else begin
            ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 1'b1;
        end
    end

    wire logic scan_start = ms_tick && (scan_ms_r + 4'd1 >= period);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_ms_r <= 4'd0;
        end else if (ms_tick) begin
            scan_ms_r <= scan_start ? 4'd0 : scan_ms_r + 4'd1;
        end
    end

    // Lowest channel still waiting in this scan.
    logic [CHW-1:0] next_ch;
    always_comb begin
        next_ch = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (pend_r[i]) begin
                next_ch = CHW'(i);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r   <= S_IDLE;
            cur_r  <= '0;
            pend_r <= '0;
        end else begin
            if (scan_start) begin
                pend_r <= pend_r | (fast ? in_use : {NCH{1'b1}});
            end
            case (st_r)
                S_IDLE: begin
                    if (pend_r != '0) begin
                        cur_r <= next_ch;
                        if (!scan_start) begin
                            pend_r[next_ch] <= 1'b0;
                        end
                        if (have_r[next_ch]) begin
                            st_r <= S_READ;
                        end
                    end
                end
                S_READ:  st_r <= S_FILT;
                S_FILT:  st_r <= S_SCALE;
                S_SCALE: st_r <= S_PUSH;
                S_PUSH: begin
                    if (buf_in_ready) begin
                        st_r <= S_IDLE;
                    end
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    // Filter: alpha = 1 - 2^-(setting+1) for settings 1..6, none at 0, computed as a shift on Q8 state.
    logic signed [16:0]       aligned_s;
    logic signed [MCC_SW-1:0] a_q;
    logic signed [MCC_SW:0]   diff;
    always_comb begin
        aligned_s = 17'(raw_r[cur_r]) + 17'(offs_r[cur_r]);
        a_q       = MCC_SW'(aligned_s) <<< MCC_FRAC;
        diff      = (MCC_SW+1)'(a_q) - (MCC_SW+1)'($signed(mem_bus.rdata));
        if (!primed_r[cur_r] || filt_r[cur_r] == 3'h0) begin
            f_nxt = a_q;
        end else begin
            f_nxt = $signed(mem_bus.rdata) + MCC_SW'(diff >>> (filt_r[cur_r] + 3'h1));
        end
    end

    assign mem_bus.addr  = cur_r;
    assign mem_bus.we    = (st_r == S_FILT);
    assign mem_bus.wdata = f_nxt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primed_r   <= '0;
            filt_val_r <= '0;
        end else begin
            if (wr_en && wch_ok && paddr[3:0] == MCC_CH_CFG) begin
                primed_r[wch] <= 1'b0;
            end
            if (st_r == S_FILT) begin
                primed_r[cur_r] <= 1'b1;
                filt_val_r      <= f_nxt;
            end
        end
    end

    // Scaling to standardized or user range.
    logic signed [18:0] x;
    logic signed [18:0] rel;
    logic signed [16:0] span;
    logic signed [54:0] prod;
    logic signed [18:0] user_v;
    logic signed [18:0] pick;
    always_comb begin
        x      = 19'(filt_val_r >>> MCC_FRAC);
        rel    = x - (bip_r[cur_r] ? -MCC_STD_FULL : MCC_STD_ZERO);
        span   = 17'(hi_r[cur_r]) - 17'(lo_r[cur_r]);
        prod   = 55'(rel) * 55'(span) * 55'(bip_r[cur_r] ? MCC_K_BIP : MCC_K_UNI);
        user_v = 19'(prod >>> MCC_SCALE_SH) + 19'(lo_r[cur_r]);
        pick   = user_r[cur_r] ? user_v : x;
        if (pick > 19'(MCC_SAT_HI)) begin
            s_nxt = MCC_SAT_HI;
        end else if (pick < 19'(MCC_SAT_LO)) begin
            s_nxt = MCC_SAT_LO;
        end else begin
            s_nxt = 16'(pick);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scaled_r <= 16'sh0000;
            for (int i = 0; i < NCH; i++) begin
                result_r[i] <= 16'sh0000;
            end
        end else begin
            if (st_r == S_SCALE) begin
                scaled_r <= s_nxt;
            end
            if (push) begin
                result_r[cur_r] <= scaled_r;
            end
        end
    end

    // Two-entry output buffer: front register plus one spare.
    logic                 spare_v_r;
    logic [CHW-1:0]       spare_ch_r;
    logic signed [15:0]   spare_d_r;
    wire logic            pop = res_valid & res_ready;
    assign buf_in_ready = ~spare_v_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_valid  <= 1'b0;
            res_ch     <= '0;
            res_data   <= 16'sh0000;
            spare_v_r  <= 1'b0;
            spare_ch_r <= '0;
            spare_d_r  <= 16'sh0000;
        end else if (pop && spare_v_r) begin
            res_ch     <= spare_ch_r;
            res_data   <= spare_d_r;
            spare_v_r  <= 1'b0;
        end else if (pop || !res_valid) begin
            res_valid <= push;
            res_ch    <= cur_r;
            res_data  <= scaled_r;
        end else if (push) begin
            spare_v_r  <= 1'b1;
            spare_ch_r <= cur_r;
            spare_d_r  <= scaled_r;
        end
    end
endmodule : mcc_top
`default_nettype wire

// File: mcc_top_asserts.sv
// Port-level checks of register access and result stream for the conditioning chain.
`timescale 1ns/1ns
`default_nettype none
module mcc_top_asserts #(
    parameter int NCH = 4,
    parameter int CHW = 2
) (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic               res_valid,
    input wire logic               res_ready,
    input wire logic [CHW-1:0]     res_ch,
    input wire logic signed [15:0] res_data
);
    localparam logic [31:0] CTRL_MASK = 32'h1 | (((32'h1 << NCH) - 32'h1) << 8);
    logic signed [31:0] rd_s;
    logic               ch_word;
    assign rd_s    = prdata;
    assign ch_word = paddr[7:4] != 4'h0;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_rd;
        pready && !pwrite && !pslverr;
    endsequence
    AST_PREADY_SETUP: assert property (s_setup |=> pready)
        else $error("no answer after setup");
    AST_PREADY_CAUSE: assert property (pready |-> $past(psel) && !$past(penable))
        else $error("answer without setup");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("answer longer than one cycle");
    AST_PRDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    AST_ERR_READY: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error without answer or with data");
    AST_OFFS_CLAMP: assert property (s_rd ##0 (ch_word && paddr[3:0] == 4'h4)
        |-> rd_s >= -32'sd1500 && rd_s <= 32'sd1500)
        else $error("offset outside clamp");
    AST_CFG_FIELDS: assert property (s_rd ##0 (ch_word && paddr[3:0] == 4'h0)
        |-> prdata[2:0] <= 3'h6 && prdata[31:6] == 26'h0 && !prdata[3])
        else $error("bad channel setting read");
    AST_CTRL_RSVD: assert property (s_rd ##0 paddr == 8'h00
        |-> (prdata & ~CTRL_MASK) == 32'h0)
        else $error("reserved control bits set");
    AST_RES_HOLD: assert property (res_valid && !res_ready
        |=> res_valid && $stable(res_ch) && $stable(res_data))
        else $error("result dropped or changed while stalled");
endmodule : mcc_top_asserts
bind mcc_top mcc_top_asserts #(.NCH(NCH), .CHW(CHW)) mcc_top_asserts_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .res_valid(res_valid), .res_ready(res_ready), .res_ch(res_ch), .res_data(res_data));
`default_nettype wire

// File: test_measurement_conditioning_chain.sv
// Self-checking bench for the conditioning chain: registers, filtering, scaling, scan rate.
`timescale 1ns/1ns
`default_nettype none
module test_measurement_conditioning_chain
    import mcc_pkg::*;
;
    localparam int NCH = 4;
    localparam int MSC = 20;
    logic               pclk, presetn, psel, penable, pwrite, raw_valid, slow, drain;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata;
    logic               pready, pslverr, res_valid, res_ready;
    logic [1:0]         raw_ch, res_ch;
    logic signed [15:0] raw_data, res_data;
    int                 n_fail, compares, cyc, last0, per;
    int                 set_m[NCH], bip_m[NCH], usr_m[NCH], off_m[NCH];
    int                 lo_m[NCH], hi_m[NCH], raw_m[NCH], prim_m[NCH];
    longint             f_m[NCH];
    logic [17:0]        expq[$];

    mcc_top #(.NCH(NCH), .MS_CYC(MSC)) mcc_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .raw_valid(raw_valid), .raw_ch(raw_ch), .raw_data(raw_data), .res_valid(res_valid),
        .res_ready(res_ready), .res_ch(res_ch), .res_data(res_data));
    mcc_sink_model mcc_sink_model_inst (
        .pclk(pclk), .presetn(presetn), .slow(slow), .res_ready(res_ready));

    always #10 pclk = ~pclk;

    task automatic close_out;
        if (n_fail == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            close_out();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input logic ex, input string nm);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, r, x);
        chk(nm, {31'h0, e}, {31'h0, ex});
    endtask : rdchk

    task automatic raw(input int c, input int v);
        @(posedge pclk);
        raw_valid <= 1'b1;
        raw_ch    <= c[1:0];
        raw_data  <= v[15:0];
        @(posedge pclk);
        raw_valid <= 1'b0;
    endtask : raw

    function automatic logic [7:0] chad(input int c, input logic [3:0] o);
        return MCC_CH_BASE + MCC_CH_STRIDE * c[7:0] + {4'h0, o};
    endfunction : chad

    // Next expected result of channel c: aligned sample, Q8 recursive filter, then scaling.
    function automatic logic [17:0] upd(input int c);
        longint a, x, y;
        a = longint'(raw_m[c] + off_m[c]) * 256;
        if (set_m[c] == 0 || prim_m[c] == 0) f_m[c] = a;
        else f_m[c] = f_m[c] + ((a - f_m[c]) >>> (set_m[c] + 1));
        prim_m[c] = 1;
        x = f_m[c] >>> 8;
        y = x;
        if (usr_m[c] != 0) y = lo_m[c] + (((x - (bip_m[c] != 0 ? -10000 : 0))
            * (hi_m[c] - lo_m[c]) * (bip_m[c] != 0 ? MCC_K_BIP : MCC_K_UNI)) >>> MCC_SCALE_SH);
        if (y > 32767) y = 32767;
        if (y < -32768) y = -32768;
        return {c[1:0], y[15:0]};
    endfunction : upd

    always @(posedge pclk) begin
        logic [17:0] e;
        cyc++;
        if (presetn === 1'b1 && res_valid === 1'b1 && res_ready === 1'b1) begin
            if (expq.size() > 0) begin
                e = expq.pop_front();
                chk("res_ch", {30'h0, res_ch}, {30'h0, e[17:16]});
                chk("res_data", 32'(res_data), 32'($signed(e[15:0])));
                if (res_ch == 2'h0 && !slow && last0 > 0) chk("period", cyc - last0, per);
                if (res_ch == 2'h0) last0 = cyc;
            end else if (!drain) begin
                chk("res_extra", 32'h1, 32'h0);
            end
        end
    end

    initial begin
        int s, c, k, p, d, m;
        logic [3:0] am;
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; raw_valid = 1'b0; raw_ch = 2'h0; raw_data = 16'sh0;
        slow = 1'b0; drain = 1'b0; n_fail = 0; compares = 0; cyc = 0; last0 = 0; per = 0;
        s = $urandom(55);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(MCC_CTRL_OFS, MCC_CTRL_RST, 1'b0, "ctrl_rst");
        rdchk(MCC_STAT_OFS, 32'h0, 1'b0, "stat_rst");
        for (c = 0; c < NCH; c++)
            for (k = 0; k < 16; k += 4) rdchk(chad(c, 4'(k)), 32'h0, 1'b0, "ch_rst");
        rdchk(8'h08, 32'h0, 1'b1, "unmapped");
        rdchk(chad(NCH, 4'h0), 32'h0, 1'b1, "no_channel");
        wr(MCC_STAT_OFS, 32'hffff_ffff);
        rdchk(MCC_STAT_OFS, 32'h0, 1'b0, "stat_ro");
        wr(MCC_CTRL_OFS, 32'hffff_ffff);
        rdchk(MCC_CTRL_OFS, 32'h0000_0f01, 1'b0, "ctrl_mask");
        wr(chad(1, MCC_CH_OFFS), 32'd2000);
        rdchk(chad(1, MCC_CH_OFFS), 32'd1500, 1'b0, "offs_hi");
        wr(chad(1, MCC_CH_OFFS), 32'hffff_f448);
        rdchk(chad(1, MCC_CH_OFFS), 32'hffff_fa24, 1'b0, "offs_lo");
        rdchk(MCC_STAT_OFS, 32'h2, 1'b0, "aligned");
        wr(chad(1, MCC_CH_OFFS), 32'h0);
        rdchk(MCC_STAT_OFS, 32'h0, 1'b0, "unaligned");
        wr(MCC_CTRL_OFS, 32'h1);
        for (p = 0; p <= 6; p++) begin
            slow <= (p >= 5);
            m = p[0] ? 5 : 15;
            per = p[0] ? (int'(MCC_T_FAST_MS) + 2) * MSC : int'(MCC_T_NORMAL_MS) * MSC;
            last0 = 0;
            for (c = 0; c < NCH; c++) begin
                set_m[c] = p; bip_m[c] = c % 2; usr_m[c] = c / 2; prim_m[c] = 0;
                off_m[c] = int'($urandom_range(3000)) - 1500;
                lo_m[c] = int'($urandom_range(65535)) - 32768;
                hi_m[c] = int'($urandom_range(65535)) - 32768;
                raw_m[c] = bip_m[c] != 0 ? int'($urandom_range(20000)) - 10000
                                         : int'($urandom_range(10000));
                am[c] = off_m[c] != 0;
                wr(chad(c, MCC_CH_CFG), {26'h0, c[1:0], 1'b0, p[2:0] | {3{p == 6}}});
                wr(chad(c, MCC_CH_OFFS), off_m[c]);
                wr(chad(c, MCC_CH_THR), {hi_m[c][15:0], lo_m[c][15:0]});
                raw(c, raw_m[c]);
            end
            for (k = 0; k < 3; k++)
                for (c = 0; c < NCH; c++) if (m[c]) expq.push_back(upd(c));
            s = expq[2 * $countones(m)];
            wr(MCC_CTRL_OFS, p[0] ? 32'h0000_0501 : 32'h0);
            for (d = 0; d < 3000 && expq.size() > 0; d++) @(posedge pclk);
            if (expq.size() > 0) begin
                n_fail++;
                close_out();
            end
            drain = 1'b1;
            wr(MCC_CTRL_OFS, 32'h1);
            repeat (200) @(posedge pclk);
            rdchk(chad(0, MCC_CH_RES), 32'($signed(s[15:0])), 1'b0, "result");
            rdchk(MCC_STAT_OFS, {20'h0, m[3:0], 4'h0, am}, 1'b0, "stat_run");
            drain = 1'b0;
        end
        close_out();
    end
endmodule : test_measurement_conditioning_chain
`default_nettype wire
